// ### logic/esbl_loader.v
// Contract
// - Start boot at reset release only when boot-select and write-protect pins are high.
// - Write-protect low at reset release skips the boot entirely.
// - Never boot once the control port is in SPI mode.
// - Act as bus master, addressing the EEPROM with read address 0xA1.
// - Serial clock at eight times sample rate, high for 3/8 of a period.
// - After boot, answer as slave at 0x68/0x69, ignoring address-select pins.
// - Parse the image as messages whose first byte is one of seven types.
// - Take every EEPROM byte most significant bit first.
// - Type 0x01 is a block write into program, parameter or control space.
// - Block write body starts with chip byte 0x00, then two address bytes.
// - Target address is 12 bits, upper bits of the field padded with zero.
// - Successive words go to consecutive locations, word size set by target.
// - Targets: 1024x5 program, 1024x4 parameter, 8x4 interface registers.
// - Program RAM starts at target address 0x0400.
// - EEPROM byte addressing reaches at least 9248 bytes.
// - Two length bytes follow the write type, then exactly that many bytes.
// - Byte 0x03 is a one-byte no-operation.
// - Byte 0x06 ends the boot and waits for a writeback trigger.
`timescale 1ns/1ps
`default_nettype none
`include "esbl_loader_regs.vh"

module esbl_loader #(
  parameter PTR_W = 14
) (
  input  wire              clk_i,
  input  wire              rst_n_i,
  input  wire              boot_source_select_pin_i,
  input  wire              wp_pin_i,
  input  wire              spi_mode_i,
  input  wire              base_clk_i,
  input  wire              sda_i,
  output wire              scl_oe_o,
  output wire              sda_oe_o,
  output wire              scl_o,
  output wire              sda_o,
  output wire              wr_valid_o,
  input  wire              wr_ready_i,
  output wire [1:0]        wr_target_o,
  output wire [11:0]       wr_addr_o,
  output wire [39:0]       wr_data_o,
  output wire [2:0]        wr_bytes_o,
  output wire              boot_busy_o,
  output wire              boot_error_o,
  output wire              wait_writeback_o,
  output wire              multi_writeback_o,
  output wire              wb_falling_edge_o,
  output wire              slave_enable_o,
  output wire [6:0]        slave_addr_o,
  output wire [PTR_W-1:0]  eeprom_ptr_o
);

  localparam M_IDLE  = 4'h0;
  localparam M_START = 4'h1;
  localparam M_ADDR  = 4'h2;
  localparam M_AACK  = 4'h3;
  localparam M_RBYTE = 4'h4;
  localparam M_PUSH  = 4'h5;
  localparam M_MACK  = 4'h6;
  localparam M_STOP  = 4'h7;
  localparam M_DONE  = 4'h8;

  localparam P_TYPE  = 3'h0;
  localparam P_LENH  = 3'h1;
  localparam P_LENL  = 3'h2;
  localparam P_BODY  = 3'h3;
  localparam P_DLY   = 3'h4;
  localparam P_END   = 3'h5;

  reg  [3:0]       sync1_q;
  reg  [3:0]       sync2_q;
  reg              lclk_prev_q;
  reg  [1:0]       st_cnt_q;
  reg              decided_q;
  reg  [3:0]       mst_q;
  reg  [2:0]       ph_q;
  reg  [2:0]       bit_q;
  reg  [7:0]       shift_q;
  reg              scl_oe_q;
  reg              sda_oe_q;
  reg              busy_q;
  reg              err_q;
  reg              slave_q;
  reg  [PTR_W-1:0] ptr_q;
  reg  [7:0]       mem_q [0:1];
  reg              fwp_q;
  reg              frp_q;
  reg  [1:0]       fcnt_q;
  reg  [2:0]       pst_q;
  reg  [15:0]      len_q;
  reg  [1:0]       bidx_q;
  reg              chip_ok_q;
  reg  [11:0]      addr_q;
  reg  [31:0]      word_q;
  reg  [2:0]       nb_q;
  reg              stop_req_q;
  reg              wr_valid_q;
  reg  [1:0]       wr_tgt_q;
  reg  [11:0]      wr_addr_q;
  reg  [39:0]      wr_data_q;
  reg  [2:0]       wr_bytes_q;
  reg              wait_wb_q;
  reg              multi_wb_q;
  reg              wb_fall_q;
  reg              scl_oe_d;
  reg              sda_oe_d;
  reg  [2:0]       wsize;
  reg  [1:0]       wtgt;

  wire       sel_s   = sync2_q[3];
  wire       wp_s    = sync2_q[2];
  wire       lclk_s  = sync2_q[1];
  wire       sda_s   = sync2_q[0];
  wire       tick    = lclk_s & ~lclk_prev_q;
  wire       bit_end = tick && (ph_q == `ESBL_PH_LAST);
  wire       sample  = tick && (ph_q == `ESBL_PH_SAMPLE);
  wire       f_in_rdy  = (fcnt_q != 2'h2);
  wire       f_out_vld = (fcnt_q != 2'h0);
  wire [7:0] f_out     = mem_q[frp_q];
  wire       f_push    = (mst_q == M_PUSH) && f_in_rdy;
  wire       f_pop     = f_out_vld && !wr_valid_q;
  wire [7:0] rx_byte   = {shift_q[6:0], sda_s};
  wire [7:0] slave_wr_byte = `ESBL_SLAVE_WR_ADDR;

  // Pins from outside the clock domain pass two flops before any use.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_q     <= 4'h0;
      sync2_q     <= 4'h0;
      lclk_prev_q <= 1'b0;
    end else begin
      sync1_q     <= {boot_source_select_pin_i, wp_pin_i, base_clk_i, sda_i};
      sync2_q     <= sync1_q;
      lclk_prev_q <= lclk_s;
    end
  end

  // Word size and target follow from where the current word lands.
  always @* begin
    if (addr_q < `ESBL_PROG_BASE) begin
      wsize = `ESBL_PARAM_BYTES;
      wtgt  = `ESBL_TGT_PARAM;
    end else if (addr_q < `ESBL_IFACE_BASE) begin
      wsize = `ESBL_PROG_BYTES;
      wtgt  = `ESBL_TGT_PROG;
    end else if (addr_q < `ESBL_IFACE_END) begin
      wsize = `ESBL_IFACE_BYTES;
      wtgt  = `ESBL_TGT_IFACE;
    end else begin
      wsize = `ESBL_CTRL_BYTES;
      wtgt  = `ESBL_TGT_CTRL;
    end
  end

  // Line drive per state and phase; an enable drives the wire low.
  // SCL is low for phases 0 to 4 and high for 5 to 7, three eighths high.
  always @* begin
    scl_oe_d = 1'b0;
    sda_oe_d = 1'b0;
    case (mst_q)
      M_START: begin
        sda_oe_d = (ph_q >= `ESBL_PH_SDA_START);
      end
      M_ADDR: begin
        scl_oe_d = (ph_q < `ESBL_PH_SCL_HIGH);
        sda_oe_d = ~shift_q[7];
      end
      M_AACK, M_RBYTE: begin
        scl_oe_d = (ph_q < `ESBL_PH_SCL_HIGH);
      end
      M_PUSH: begin
        scl_oe_d = 1'b1;
      end
      M_MACK: begin
        scl_oe_d = (ph_q < `ESBL_PH_SCL_HIGH);
        // The answer bit is frozen while SCL is high, or a late stop request would look like a stop.
        sda_oe_d = (ph_q < `ESBL_PH_SCL_HIGH) ? ~stop_req_q : sda_oe_q;
      end
      M_STOP: begin
        scl_oe_d = (ph_q < `ESBL_PH_SCL_HIGH);
        sda_oe_d = (ph_q < `ESBL_PH_SDA_STOP);
      end
      default: begin
        scl_oe_d = 1'b0;
        sda_oe_d = 1'b0;
      end
    endcase
  end

  // Bus master: strap decision, address phase and sequential byte reads.
  // Holding SCL low in the push state stalls the EEPROM while the buffer is full.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_cnt_q  <= 2'h0;
      decided_q <= 1'b0;
      mst_q     <= M_IDLE;
      ph_q      <= 3'h0;
      bit_q     <= 3'h0;
      shift_q   <= 8'h00;
      scl_oe_q  <= 1'b0;
      sda_oe_q  <= 1'b0;
      busy_q    <= 1'b0;
      err_q     <= 1'b0;
      slave_q   <= 1'b0;
      ptr_q     <= {PTR_W{1'b0}};
    end else begin
      scl_oe_q <= scl_oe_d;
      // SDA waits one cycle while SCL is being pulled low, so it only moves with SCL high for a start or a stop.
      if (!(scl_oe_d && !scl_oe_q)) begin
        sda_oe_q <= sda_oe_d;
      end
      if (tick && mst_q != M_IDLE && mst_q != M_PUSH && mst_q != M_DONE) begin
        ph_q <= ph_q + 3'h1;
      end
      case (mst_q)
        M_IDLE: begin
          if (!decided_q) begin
            if (st_cnt_q != `ESBL_STARTUP_CYC) begin
              st_cnt_q <= st_cnt_q + 2'h1;
            end else begin
              decided_q <= 1'b1;
              if (sel_s && wp_s && !spi_mode_i) begin
                mst_q  <= M_START;
                ph_q   <= 3'h0;
                busy_q <= 1'b1;
              end else begin
                mst_q   <= M_DONE;
                slave_q <= !spi_mode_i;
              end
            end
          end
        end
        M_START: begin
          if (bit_end) begin
            mst_q   <= M_ADDR;
            shift_q <= `ESBL_EEPROM_RD_ADDR;
            bit_q   <= 3'h7;
          end
        end
        M_ADDR: begin
          if (bit_end) begin
            shift_q <= {shift_q[6:0], 1'b0};
            bit_q   <= bit_q - 3'h1;
            if (bit_q == 3'h0) begin
              mst_q <= M_AACK;
            end
          end
        end
        M_AACK: begin
          if (sample && sda_s) begin
            err_q <= 1'b1;
          end
          if (bit_end) begin
            mst_q <= err_q ? M_STOP : M_RBYTE;
            bit_q <= 3'h7;
          end
        end
        M_RBYTE: begin
          if (sample) begin
            shift_q <= rx_byte;
          end
          if (bit_end) begin
            bit_q <= bit_q - 3'h1;
            if (bit_q == 3'h0) begin
              mst_q <= M_PUSH;
            end
          end
        end
        M_PUSH: begin
          if (f_in_rdy) begin
            mst_q <= M_MACK;
            ptr_q <= ptr_q + {{(PTR_W-1){1'b0}}, 1'b1};
          end
        end
        M_MACK: begin
          if (bit_end) begin
            mst_q <= sda_oe_q ? M_RBYTE : M_STOP; // Follow the answer actually sent.
            bit_q <= 3'h7;
          end
        end
        M_STOP: begin
          if (bit_end) begin
            mst_q   <= M_DONE;
            busy_q  <= 1'b0;
            slave_q <= 1'b1;
          end
        end
        default: begin
          mst_q <= M_DONE;
        end
      endcase
    end
  end

  // Two-entry byte buffer between the receiver and the message parser.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fwp_q    <= 1'b0;
      frp_q    <= 1'b0;
      fcnt_q   <= 2'h0;
      mem_q[0] <= 8'h00;
      mem_q[1] <= 8'h00;
    end else begin
      if (f_push) begin
        mem_q[fwp_q] <= shift_q;
        fwp_q        <= ~fwp_q;
      end
      if (f_pop) begin
        frp_q <= ~frp_q;
      end
      if (f_push && !f_pop) begin
        fcnt_q <= fcnt_q + 2'h1;
      end else if (f_pop && !f_push) begin
        fcnt_q <= fcnt_q - 2'h1;
      end
    end
  end

  // Message parser. A write stalls the buffer until the target takes it.
  // Unknown type codes end the boot, since nothing after them can be trusted.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pst_q      <= P_TYPE;
      len_q      <= 16'h0000;
      bidx_q     <= 2'h0;
      chip_ok_q  <= 1'b0;
      addr_q     <= 12'h000;
      word_q     <= 32'h0000_0000;
      nb_q       <= 3'h0;
      stop_req_q <= 1'b0;
      wr_valid_q <= 1'b0;
      wr_tgt_q   <= 2'h0;
      wr_addr_q  <= 12'h000;
      wr_data_q  <= 40'h00_0000_0000;
      wr_bytes_q <= 3'h0;
      wait_wb_q  <= 1'b0;
      multi_wb_q <= 1'b0;
      wb_fall_q  <= 1'b0;
    end else begin
      if (wr_valid_q && wr_ready_i) begin
        wr_valid_q <= 1'b0;
      end
      if (err_q) begin
        pst_q <= P_END;
      end else if (f_pop) begin
        case (pst_q)
          P_TYPE: begin
            case (f_out)
              `ESBL_MSG_WRITE:    pst_q <= P_LENH;
              `ESBL_MSG_DELAY:    pst_q <= P_LENH;
              `ESBL_MSG_NOP:      pst_q <= P_TYPE;
              `ESBL_MSG_MULTI_WB: multi_wb_q <= 1'b1;
              `ESBL_MSG_WB_FALL:  wb_fall_q <= 1'b1;
              `ESBL_MSG_END_WAIT: begin
                pst_q      <= P_END;
                wait_wb_q  <= 1'b1;
                stop_req_q <= 1'b1;
              end
              default: begin
                pst_q      <= P_END;
                stop_req_q <= 1'b1;
              end
            endcase
            bidx_q <= (f_out == `ESBL_MSG_DELAY) ? 2'h3 : 2'h0;
          end
          P_LENH: begin
            len_q[15:8] <= f_out;
            pst_q       <= P_LENL;
          end
          P_LENL: begin
            len_q[7:0] <= f_out;
            nb_q       <= 3'h0;
            if (bidx_q == 2'h3) begin
              pst_q <= P_TYPE;
            end else if ({len_q[15:8], f_out} == 16'h0000) begin
              pst_q <= P_TYPE;
            end else begin
              pst_q <= P_BODY;
            end
          end
          P_BODY: begin
            len_q <= len_q - 16'h0001;
            if (len_q == 16'h0001) begin
              pst_q <= P_TYPE;
            end
            if (bidx_q == 2'h0) begin
              chip_ok_q <= (f_out == `ESBL_BODY_CHIP);
              bidx_q    <= 2'h1;
            end else if (bidx_q == 2'h1) begin
              addr_q[11:8] <= f_out[3:0];
              bidx_q       <= 2'h2;
            end else if (bidx_q == 2'h2) begin
              addr_q[7:0] <= f_out;
              bidx_q      <= 2'h3;
            end else if (nb_q + 3'h1 == wsize) begin
              nb_q       <= 3'h0;
              addr_q     <= addr_q + 12'h001;
              wr_valid_q <= chip_ok_q;
              wr_tgt_q   <= wtgt;
              wr_addr_q  <= addr_q;
              wr_data_q  <= {word_q, f_out};
              wr_bytes_q <= wsize;
            end else begin
              nb_q   <= nb_q + 3'h1;
              word_q <= {word_q[23:0], f_out};
            end
          end
          default: begin
            pst_q <= P_END;
          end
        endcase
      end
    end
  end

  assign scl_oe_o          = scl_oe_q;
  assign sda_oe_o          = sda_oe_q;
  assign scl_o             = 1'b0;
  assign sda_o             = 1'b0;
  assign wr_valid_o        = wr_valid_q;
  assign wr_target_o       = wr_tgt_q;
  assign wr_addr_o         = wr_addr_q;
  assign wr_data_o         = wr_data_q;
  assign wr_bytes_o        = wr_bytes_q;
  assign boot_busy_o       = busy_q;
  assign boot_error_o      = err_q;
  assign wait_writeback_o  = wait_wb_q;
  assign multi_writeback_o = multi_wb_q;
  assign wb_falling_edge_o = wb_fall_q;
  assign slave_enable_o    = slave_q;
  assign slave_addr_o      = slave_wr_byte[7:1];
  assign eeprom_ptr_o      = ptr_q;

endmodule

`default_nettype wire

// ### logic/esbl_loader_regs.vh
`ifndef ESBL_LOADER_REGS_VH
`define ESBL_LOADER_REGS_VH
// Bus addresses on the two-wire link, full byte with the direction bit.
`define ESBL_EEPROM_RD_ADDR 8'hA1
`define ESBL_SLAVE_WR_ADDR  8'h68
`define ESBL_SLAVE_RD_ADDR  8'h69
// Message type codes found in the boot image.
`define ESBL_MSG_END        8'h00
`define ESBL_MSG_WRITE      8'h01
`define ESBL_MSG_DELAY      8'h02
`define ESBL_MSG_NOP        8'h03
`define ESBL_MSG_MULTI_WB   8'h04
`define ESBL_MSG_WB_FALL    8'h05
`define ESBL_MSG_END_WAIT   8'h06
// Required chip address byte at the head of a block write body.
`define ESBL_BODY_CHIP      8'h00
// Internal address map bases.
`define ESBL_PROG_BASE      12'h400
`define ESBL_IFACE_BASE     12'h800
`define ESBL_IFACE_END      12'h808
// Bytes per word of each target.
`define ESBL_PARAM_BYTES    3'h4
`define ESBL_PROG_BYTES     3'h5
`define ESBL_IFACE_BYTES    3'h4
`define ESBL_CTRL_BYTES     3'h2
// Target codes reported with each word write.
`define ESBL_TGT_PARAM      2'h0
`define ESBL_TGT_PROG       2'h1
`define ESBL_TGT_IFACE      2'h2
`define ESBL_TGT_CTRL       2'h3
// Serial clock phases: eight base ticks per bit, three of them high.
`define ESBL_PH_LAST        3'h7
`define ESBL_PH_SCL_HIGH    3'h5
`define ESBL_PH_SAMPLE      3'h6
`define ESBL_PH_SDA_START   3'h4
`define ESBL_PH_SDA_STOP    3'h6
// Cycles after reset release before the straps are judged.
`define ESBL_STARTUP_CYC    2'h3
`endif

// ### verification/esbl_eeprom_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "esbl_loader_regs.vh"
// Serial memory answering current-address reads on the two-wire link.
module esbl_eeprom_model (
  input  wire logic        rst_n_i,
  input  wire logic        nack_addr_i,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output var  logic        sda_oe_o = 1'b0,
  output var  logic [7:0]  addr_seen_o = 8'h00,
  output var  logic [15:0] ptr_o = 16'h0000
);
  localparam int N = 63;
  localparam logic [8*N-1:0] IMG = {64'h01000500081C0040, 16'h0303, 72'h010006010000AABBCC,
    128'h01000D000400112233445566778899AA, 96'h010009000010010203040506,
    80'h010007000803DEADBEEF, 48'h021234040506};
  logic [3:0] bitn = 4'h0;
  logic [7:0] sh = 8'h00;
  logic [7:0] cur;
  logic       active = 1'b0;
  logic       sending = 1'b0;
  logic       done = 1'b0;
  logic       prev_oe;
  // Past the image the cells read as erased.
  function automatic logic [7:0] byte_at(input logic [15:0] i);
    if (i < 16'(N)) return IMG[8*(N-1-int'(i)) +: 8];
    return 8'hFF;
  endfunction
  // Power cycles with the board, so the read pointer starts over.
  always @(negedge rst_n_i) begin
    ptr_o = 16'h0000;
    active = 1'b0;
    sda_oe_o = 1'b0;
    addr_seen_o = 8'h00;
  end
  // A start opens a frame; the first falling clock then brings bit 0.
  always @(negedge sda_i) begin
    if (scl_i === 1'b1) begin
      active = 1'b1;
      sending = 1'b0;
      done = 1'b0;
      bitn = 4'hF;
    end
  end
  // A stop closes the frame and lets go of the data line.
  always @(posedge sda_i) begin
    if (scl_i === 1'b1) begin
      active = 1'b0;
      sda_oe_o = 1'b0;
    end
  end
  // Address bits are taken most significant first; a high answer from the master ends a read.
  always @(posedge scl_i) begin
    if (active && !sending && bitn < 4'h8) sh = {sh[6:0], sda_i};
    if (active && sending && bitn == 4'h8) begin
      done = (sda_i === 1'b1);
      ptr_o = ptr_o + 16'h0001;
    end
  end
  // The line only moves while the clock is low, and only when addressed.
  always @(negedge scl_i) begin
    if (active) begin
      prev_oe = sda_oe_o;
      bitn = (bitn == 4'h8) ? 4'h0 : bitn + 4'h1;
      sda_oe_o = 1'b0;
      cur = byte_at(ptr_o);
      if (bitn == 4'h0 && !sending && prev_oe) sending = 1'b1;
      if (sending && done) begin
        active = 1'b0;
      end else if (sending && bitn < 4'h8) begin
        sda_oe_o = !cur[3'h7 - bitn[2:0]];
      end else if (!sending && bitn == 4'h8) begin
        addr_seen_o = sh;
        sda_oe_o = (sh == `ESBL_EEPROM_RD_ADDR) && !nack_addr_i;
      end
    end
  end
endmodule
`default_nettype wire

// ### verification/esbl_checker.sv
`timescale 1ns/1ps
`default_nettype none
// Pin-level checks of the loader, all in the system clock domain.
module esbl_checker (
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic        boot_source_select_pin_i,
  input wire logic        wp_pin_i,
  input wire logic        spi_mode_i,
  input wire logic        base_clk_i,
  input wire logic        scl_oe_o,
  input wire logic        sda_oe_o,
  input wire logic        wr_valid_o,
  input wire logic        wr_ready_i,
  input wire logic [1:0]  wr_target_o,
  input wire logic [11:0] wr_addr_o,
  input wire logic [39:0] wr_data_o,
  input wire logic [2:0]  wr_bytes_o,
  input wire logic        boot_busy_o,
  input wire logic        wait_writeback_o,
  input wire logic        slave_enable_o,
  input wire logic [6:0]  slave_addr_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic       base_q;
  logic [3:0] hi_cnt_q;
  logic       seen_low_q;
  // Counts base ticks while the clock line is released; a stall held low cannot inflate it.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      base_q <= 1'b0;
      hi_cnt_q <= 4'h0;
      seen_low_q <= 1'b0;
    end else begin
      base_q <= base_clk_i;
      if (scl_oe_o) begin
        hi_cnt_q <= 4'h0;
        seen_low_q <= 1'b1;
      end else if (base_clk_i && !base_q) begin
        hi_cnt_q <= hi_cnt_q + 4'h1;
      end
    end
  end
  boot_straps_a: assert property ($rose(boot_busy_o) |->
    boot_source_select_pin_i && wp_pin_i && !spi_mode_i) else $error("boot without straps");
  scl_duty_a: assert property ($rose(scl_oe_o) && seen_low_q && boot_busy_o |->
    hi_cnt_q == 4'h3) else $error("clock high time not three ticks");
  valid_hold_a: assert property (wr_valid_o && !wr_ready_i |=> wr_valid_o &&
    $stable(wr_addr_o) && $stable(wr_data_o) && $stable({wr_target_o, wr_bytes_o}))
    else $error("word changed before taken");
  word_size_a: assert property (wr_valid_o |-> wr_bytes_o ==
    ((wr_target_o == 2'h1) ? 3'h5 : (wr_target_o == 2'h3) ? 3'h2 : 3'h4)) else $error("bad size");
  prog_base_a: assert property (wr_valid_o |->
    (wr_target_o == 2'h1) == (wr_addr_o[11:10] == 2'h1)) else $error("program range wrong");
  param_range_a: assert property (wr_valid_o && wr_target_o == 2'h0 |->
    wr_addr_o[11:10] == 2'h0) else $error("parameter range wrong");
  iface_range_a: assert property (wr_valid_o && wr_target_o == 2'h2 |->
    wr_addr_o[11:3] == 9'h100) else $error("interface range wrong");
  end_release_a: assert property ($fell(boot_busy_o) |-> ##[0:100]
    (slave_enable_o && !scl_oe_o && !sda_oe_o)) else $error("bus not handed back");
  ww_sticky_a: assert property (wait_writeback_o |=> wait_writeback_o)
    else $error("wait flag dropped");
  slave_addr_a: assert property (slave_addr_o == 7'h34) else $error("slave address wrong");
endmodule
bind esbl_loader esbl_checker chk (.clk_i, .rst_n_i, .boot_source_select_pin_i, .wp_pin_i,
  .spi_mode_i, .base_clk_i, .scl_oe_o, .sda_oe_o, .wr_valid_o, .wr_ready_i, .wr_target_o,
  .wr_addr_o, .wr_data_o, .wr_bytes_o, .boot_busy_o, .wait_writeback_o, .slave_enable_o,
  .slave_addr_o);
`default_nettype wire

// ### verification/tb_esbl_loader.sv
`timescale 1ns/1ps
`default_nettype none
// Boots the loader from a memory model and judges every word it writes.
module tb_esbl_loader;
  logic        clk_i = 1'b0, rst_n_i = 1'b0, base_clk_i = 1'b0, wr_ready_i = 1'b1;
  logic        boot_source_select_pin_i = 1'b0, wp_pin_i = 1'b0, spi_mode_i = 1'b0;
  logic        nack_addr = 1'b0, busy_seen, eep_oe;
  logic [7:0]  addr_seen;
  wire         scl_oe_o, sda_oe_o, wr_valid_o, boot_busy_o, boot_error_o, slave_enable_o;
  wire         wait_writeback_o, multi_writeback_o, wb_falling_edge_o;
  wire [1:0]   wr_target_o;
  wire [11:0]  wr_addr_o;
  wire [39:0]  wr_data_o;
  wire [2:0]   wr_bytes_o;
  wire [6:0]   slave_addr_o;
  wire         scl_lvl, sda_lvl;
  wire [13:0]  ptr_w;
  wire [15:0]  eptr_w;
  wire         scl_w = !scl_oe_o;
  wire         sda_w = !(sda_oe_o || eep_oe);
  int          n_errors = 0, n_checks = 0, n_wr, hold;
  logic [1:0]  e_tgt [0:4] = '{2'h3, 2'h1, 2'h1, 2'h0, 2'h2};
  logic [11:0] e_addr [0:4] = '{12'h81C, 12'h400, 12'h401, 12'h010, 12'h803};
  logic [2:0]  e_len [0:4] = '{3'h2, 3'h5, 3'h5, 3'h4, 3'h4};
  logic [39:0] e_data [0:4] = '{40'h40, 40'h1122334455, 40'h66778899AA, 40'h01020304, 40'hDEADBEEF};

  esbl_loader dut (.clk_i, .rst_n_i, .boot_source_select_pin_i, .wp_pin_i, .spi_mode_i,
    .base_clk_i, .sda_i(sda_w), .scl_oe_o, .sda_oe_o, .scl_o(scl_lvl), .sda_o(sda_lvl), .wr_valid_o,
    .wr_ready_i, .wr_target_o, .wr_addr_o, .wr_data_o, .wr_bytes_o, .boot_busy_o, .boot_error_o,
    .wait_writeback_o, .multi_writeback_o, .wb_falling_edge_o, .slave_enable_o, .slave_addr_o,
    .eeprom_ptr_o(ptr_w));
  esbl_eeprom_model eep (.rst_n_i, .nack_addr_i(nack_addr), .scl_i(scl_w), .sda_i(sda_w),
    .sda_oe_o(eep_oe), .addr_seen_o(addr_seen), .ptr_o(eptr_w));

  // The base tick is offset so its edges never meet a system clock edge.
  initial forever #5 clk_i = ~clk_i;
  initial begin
    #3;
    forever #62.5 base_clk_i = ~base_clk_i;
  end

  task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Every accepted word is compared with the next one the image should yield.
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      n_wr <= 0;
      busy_seen <= 1'b0;
    end else begin
      if (boot_busy_o === 1'b1) busy_seen <= 1'b1;
      if (wr_valid_o === 1'b1 && wr_ready_i === 1'b1 && n_wr < 5) begin
        check("target", 40'(wr_target_o), 40'(e_tgt[n_wr]));
        check("addr", 40'(wr_addr_o), 40'(e_addr[n_wr]));
        // Only the low bytes of a word are defined; the rest may hold older bytes.
        check("data", wr_data_o & ~(~40'h0 << (8 * e_len[n_wr])), e_data[n_wr]);
        check("bytes", 40'(wr_bytes_o), 40'(e_len[n_wr]));
      end
      if (wr_valid_o === 1'b1 && wr_ready_i === 1'b1) n_wr <= n_wr + 1;
    end
  end

  // The second word is held off long enough that the byte buffer fills and the link stalls.
  always @(negedge clk_i) begin
    if (!rst_n_i) hold = 0;
    if (wr_valid_o === 1'b1 && n_wr == 1 && hold < 3000) begin
      hold++;
      wr_ready_i = 1'b0;
    end else begin
      wr_ready_i = 1'b1;
    end
  end

  task automatic start(input logic sel, input logic wp, input logic spi, input logic nack);
    @(negedge clk_i);
    rst_n_i = 1'b0;
    boot_source_select_pin_i = sel;
    wp_pin_i = wp;
    spi_mode_i = spi;
    nack_addr = nack;
    repeat (8) @(negedge clk_i);
    rst_n_i = 1'b1;
  endtask

  task automatic wait_slave(input int lim);
    for (int i = 0; i < lim && slave_enable_o !== 1'b1; i++) @(negedge clk_i);
    repeat (200) @(negedge clk_i);
  endtask

  task automatic t_full;
    start(1'b1, 1'b1, 1'b0, 1'b0);
    wait_slave(90000);
    check("writes", 40'(n_wr), 40'h5);
    check("address", 40'(addr_seen), 40'hA1);
    check("boot seen", 40'(busy_seen), 40'h1);
    check("flags", 40'({boot_busy_o, boot_error_o, wait_writeback_o, multi_writeback_o,
      wb_falling_edge_o, slave_enable_o}), 40'h0F);
    check("lines", 40'({scl_w, sda_w}), 40'h3);
    check("slave addr", 40'(slave_addr_o), 40'h34);
    check("bytes read", 40'(ptr_w), 40'(eptr_w));
    check("drive level", 40'({scl_lvl, sda_lvl}), 40'h0);
    $display("test full boot done");
  endtask

  task automatic t_nack;
    start(1'b1, 1'b1, 1'b0, 1'b1);
    wait_slave(20000);
    check("nack", 40'({boot_error_o, slave_enable_o, busy_seen, wait_writeback_o}), 40'hE);
    check("writes", 40'(n_wr), 40'h0);
    $display("test refused address done");
  endtask

  // Straps that come right only after the decision must not start a boot.
  task automatic t_skip(input logic sel, input logic wp, input logic spi, input logic slv);
    start(sel, wp, spi, 1'b0);
    repeat (100) @(negedge clk_i);
    boot_source_select_pin_i = 1'b1;
    wp_pin_i = 1'b1;
    repeat (3000) @(negedge clk_i);
    check("skip", 40'({busy_seen, addr_seen, slave_enable_o}), 40'(slv));
    $display("test skipped boot done");
  endtask

  initial begin
    t_full();
    t_nack();
    t_skip(1'b1, 1'b0, 1'b0, 1'b1);
    t_skip(1'b0, 1'b1, 1'b0, 1'b1);
    t_skip(1'b1, 1'b1, 1'b1, 1'b0);
    results();
  end

  // The tests need about 70000 cycles; give them ample room.
  initial begin
    repeat (150000) @(posedge clk_i);
    n_errors++;
    $display("watchdog expired");
    results();
  end
endmodule
`default_nettype wire
